/* utcp_defines.svh */
`ifndef UTCP_DEFINES_SVH
`define UTCP_DEFINES_SVH

// ----------------------------------------------------------------------------
// serial timing
// ----------------------------------------------------------------------------
`define UTCP_CLK_HZ        20000000
`define UTCP_BAUD_HIGH     2400
`define UTCP_BAUD_LOW      1200
`define UTCP_DIV_HIGH      (`UTCP_CLK_HZ / `UTCP_BAUD_HIGH)
`define UTCP_DIV_LOW       (`UTCP_CLK_HZ / `UTCP_BAUD_LOW)
`define UTCP_DATA_BITS     7
`define UTCP_STOP_BITS     1

// ----------------------------------------------------------------------------
// character codes
// ----------------------------------------------------------------------------
`define UTCP_CH_CR         7'h0D
`define UTCP_CH_BS         7'h08
`define UTCP_CH_DEL        7'h7F
`define UTCP_CH_CTRL_B     7'h02
`define UTCP_CH_CTRL_C     7'h03
`define UTCP_CH_SLASH      7'h2F
`define UTCP_CH_COLON      7'h3A
`define UTCP_CH_LO_D       7'h64
`define UTCP_CH_LO_T       7'h74
`define UTCP_CH_ZERO       7'h30
`define UTCP_CASE_BIT      5

// ----------------------------------------------------------------------------
// line buffer
// ----------------------------------------------------------------------------
`define UTCP_LINE_LEN      10
`define UTCP_IDX_W         4
`define UTCP_MOD_MAX       3'h6

`endif

/* utcp_pkg.sv */
package utcp_pkg;

  // report selected by a finished command line
  typedef enum logic [3:0] {
    UTCP_RPT_NONE    = 4'h0,
    UTCP_RPT_STATUS  = 4'h1,
    UTCP_RPT_EVENTS  = 4'h2,
    UTCP_RPT_HISTORY = 4'h3,
    UTCP_RPT_BIN0    = 4'h4,
    UTCP_RPT_BIN1    = 4'h5,
    UTCP_RPT_BIN2    = 4'h6,
    UTCP_RPT_BIN3    = 4'h7,
    UTCP_RPT_SUMMARY = 4'h8,
    UTCP_RPT_DETAIL  = 4'h9
  } utcp_rpt_t;

  // transmit side of the uart
  typedef enum logic [1:0] {
    UTCP_TX_IDLE  = 2'b00,
    UTCP_TX_SHIFT = 2'b01
  } utcp_tx_st_t;

endpackage : utcp_pkg

/* utcp_uart_rx.sv */
`timescale 1ns/100ps
`include "utcp_defines.svh"

// 7 data bits, odd parity, 1 stop; a character with bad parity or stop is dropped
module utcp_uart_rx (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        baud_low,
  input  wire logic        rxd,
  output logic             rx_valid,
  output logic [6:0]       rx_char
);

  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic [9:0]  sh_q;
  logic        busy_q;
  logic [15:0] div_w;
  logic        tick_w;

  // baud divider picks the port rate, half period centres the start bit
  assign div_w  = baud_low ? 16'(`UTCP_DIV_LOW) : 16'(`UTCP_DIV_HIGH);
  assign tick_w = busy_q && (cnt_q == 16'h0000);

  // shift sampled bits in lsb first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 16'h0000;
      bit_q    <= 4'h0;
      sh_q     <= 10'h000;
      busy_q   <= 1'b0;
      rx_valid <= 1'b0;
      rx_char  <= 7'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!busy_q) begin
        if (!rxd) begin
          busy_q <= 1'b1;
          cnt_q  <= div_w >> 1;
          bit_q  <= 4'h0;
        end
      end else if (tick_w) begin
        sh_q  <= {rxd, sh_q[9:1]};
        cnt_q <= div_w - 16'h0001;
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h9) begin
          busy_q <= 1'b0;
          // odd parity: data plus parity bit hold an odd count of ones
          if ((^sh_q[9:2]) && rxd && !sh_q[1]) begin
            rx_valid <= 1'b1;
            rx_char  <= sh_q[8:2];
          end
        end
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

endmodule : utcp_uart_rx

/* utcp_uart_tx.sv */
`timescale 1ns/100ps
`include "utcp_defines.svh"

// 7 data bits, odd parity, 1 stop; ready while idle
module utcp_uart_tx (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        baud_low,
  input  wire logic        tx_valid,
  input  wire logic [6:0]  tx_char,
  output logic             tx_ready,
  output logic             txd
);

  utcp_pkg::utcp_tx_st_t st_q;
  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic [9:0]  sh_q;
  logic [15:0] div_w;

  assign div_w    = baud_low ? 16'(`UTCP_DIV_LOW) : 16'(`UTCP_DIV_HIGH);
  assign tx_ready = (st_q == utcp_pkg::UTCP_TX_IDLE);

  // frame is stop, parity, data, start from msb down
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= utcp_pkg::UTCP_TX_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q  <= 10'h3FF;
      txd   <= 1'b1;
    end else begin
      unique case (st_q)
        utcp_pkg::UTCP_TX_IDLE: begin
          txd <= 1'b1;
          if (tx_valid) begin
            sh_q  <= {1'b1, ~^tx_char, tx_char, 1'b0};
            st_q  <= utcp_pkg::UTCP_TX_SHIFT;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
          end
        end
        utcp_pkg::UTCP_TX_SHIFT: begin
          if (cnt_q == 16'h0000) begin
            txd   <= sh_q[0];
            sh_q  <= {1'b1, sh_q[9:1]};
            cnt_q <= div_w - 16'h0001;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'hA) begin
              st_q <= utcp_pkg::UTCP_TX_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

endmodule : utcp_uart_tx

/* utcp_port.sv */
`timescale 1ns/100ps
`include "utcp_defines.svh"

// Notes on behaviour
// - status key then return asks the status report; trailing digit picks module.
// - report command without digit selects the central system cabinet.
// - control-B command asks event history, newest frame first.
// - history command asks history status frames, newest first.
// - freeze key acts at once and toggles output suspension.
// - buffer-reset command unfreezes and clears the fault history buffer.
// - quit key acts at once, stops output, next report restarts.
// - lower-case d with mm/dd/yy and return loads the clock date.
// - lower-case t with hh:mm:ss and return loads the clock time.
// - date and time commands are accepted only in lower case.
// - hang-up command releases the modem line, modem port only.
// - four battery-bin commands report 0-30, 31-90, 91-240, over 240 s.
// - a command asks the battery discharge summary screen.
// - a command asks all discharge records, newest first.
// - backspace removes the previously entered character.
// - interface serves a modem plus local terminal or monitor.
// - every port runs concurrently and independently of the others.
// - eight panel indications also drive customer contact outputs.
// - framing is 7 data, odd parity, 1 stop, full duplex.
// - local port 2400 baud only; modem port 1200 or 2400.
// - other command letters accepted in either case.
// - local terminal gets the status report on every new alarm.
module utcp_port (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         is_modem,
  input  wire logic         baud_low,
  input  wire logic         rxd,
  output logic              txd,
  input  wire logic         new_alarm,
  output logic              rpt_start,
  output utcp_pkg::utcp_rpt_t rpt_kind,
  output logic [2:0]        rpt_module,
  input  wire logic         rpt_valid,
  input  wire logic [6:0]   rpt_char,
  output logic              rpt_ready,
  output logic              rpt_abort,
  output logic              hist_reset,
  output logic              date_load,
  output logic              time_load,
  output logic [5:0][3:0]   clk_digits,
  output logic              hang_up
);

  // --------------------------------------------------------------------------
  // serial line
  // --------------------------------------------------------------------------
  logic       rx_valid;
  logic [6:0] rx_char;
  logic       tx_ready;
  logic       eff_low;
  logic       frozen_q;

  assign eff_low = is_modem & baud_low;

  utcp_uart_rx u_rx (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .baud_low (eff_low),
    .rxd      (rxd),
    .rx_valid (rx_valid),
    .rx_char  (rx_char)
  );

  utcp_uart_tx u_tx (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .baud_low (eff_low),
    .tx_valid (rpt_valid && !frozen_q),
    .tx_char  (rpt_char),
    .tx_ready (tx_ready),
    .txd      (txd)
  );

  // --------------------------------------------------------------------------
  // line buffer
  // --------------------------------------------------------------------------
  logic [`UTCP_LINE_LEN-1:0][6:0] line_q;
  logic [`UTCP_IDX_W-1:0]         len_q;
  logic                           alarm_q;
  logic                           alarm_in_q;

  // fold a letter to upper case so commands match either case
  function automatic logic [6:0] utcp_upper(input logic [6:0] c);
    utcp_upper = ((c >= 7'h61) && (c <= 7'h7A)) ? (c & ~(7'h01 << `UTCP_CASE_BIT)) : c;
  endfunction : utcp_upper

  // digit value 1..6 or zero when the character is not a module digit
  function automatic logic [2:0] utcp_module(input logic [6:0] c);
    logic [6:0] v;
    v = c - `UTCP_CH_ZERO;
    utcp_module = ((v >= 7'h01) && (v <= 7'(`UTCP_MOD_MAX))) ? v[2:0] : 3'h0;
  endfunction : utcp_module

  function automatic logic utcp_is_digit(input logic [6:0] c);
    utcp_is_digit = (c >= 7'h30) && (c <= 7'h39);
  endfunction : utcp_is_digit

  logic is_cr, is_bs, is_freeze, is_quit;
  logic [6:0] c0;
  logic [2:0] mod_w;
  logic       mod_ok;
  logic       len1, len2;

  assign is_cr     = rx_valid && (rx_char == `UTCP_CH_CR);
  assign is_bs     = rx_valid && ((rx_char == `UTCP_CH_BS) || (rx_char == `UTCP_CH_DEL));
  assign is_freeze = rx_valid && (len_q == '0) && (utcp_upper(rx_char) == 7'h46);
  assign is_quit   = rx_valid && (len_q == '0) && (utcp_upper(rx_char) == 7'h51);
  assign c0        = utcp_upper(line_q[0]);
  assign len1      = (len_q == `UTCP_IDX_W'(1));
  assign len2      = (len_q == `UTCP_IDX_W'(2));
  assign mod_w     = len2 ? utcp_module(line_q[1]) : 3'h0;
  assign mod_ok    = len1 || (len2 && (mod_w != 3'h0));

  // --------------------------------------------------------------------------
  // date and time line checks
  // --------------------------------------------------------------------------
  logic clk_shape_ok;
  logic [6:0] sep_w;
  logic is_date, is_time;

  assign is_date = (line_q[0] == `UTCP_CH_LO_D);
  assign is_time = (line_q[0] == `UTCP_CH_LO_T);
  assign sep_w   = is_date ? `UTCP_CH_SLASH : `UTCP_CH_COLON;

  // layout "x nn?nn?nn" with the separator mandatory
  assign clk_shape_ok = (len_q == `UTCP_IDX_W'(`UTCP_LINE_LEN)) && (line_q[1] == 7'h20)
                     && utcp_is_digit(line_q[2]) && utcp_is_digit(line_q[3])
                     && (line_q[4] == sep_w)
                     && utcp_is_digit(line_q[5]) && utcp_is_digit(line_q[6])
                     && (line_q[7] == sep_w)
                     && utcp_is_digit(line_q[8]) && utcp_is_digit(line_q[9]);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          clk_digits[2*gi+1] <= 4'h0;
          clk_digits[2*gi]   <= 4'h0;
        end else if (is_cr && (is_date || is_time) && clk_shape_ok) begin
          clk_digits[2*gi+1] <= line_q[2+3*gi][3:0];
          clk_digits[2*gi]   <= line_q[3+3*gi][3:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // command decode on return
  // --------------------------------------------------------------------------
  utcp_pkg::utcp_rpt_t kind_w;

  always_comb begin
    kind_w = utcp_pkg::UTCP_RPT_NONE;
    if (mod_ok) begin
      unique case (c0)
        7'h41:          kind_w = utcp_pkg::UTCP_RPT_STATUS;
        `UTCP_CH_CTRL_B: kind_w = utcp_pkg::UTCP_RPT_EVENTS;
        7'h43, `UTCP_CH_CTRL_C: kind_w = utcp_pkg::UTCP_RPT_HISTORY;
        default:        kind_w = utcp_pkg::UTCP_RPT_NONE;
      endcase
    end
    if (len1) begin
      unique case (c0)
        7'h49:   kind_w = utcp_pkg::UTCP_RPT_BIN0;
        7'h4A:   kind_w = utcp_pkg::UTCP_RPT_BIN1;
        7'h4B:   kind_w = utcp_pkg::UTCP_RPT_BIN2;
        7'h4C:   kind_w = utcp_pkg::UTCP_RPT_BIN3;
        7'h4D:   kind_w = utcp_pkg::UTCP_RPT_SUMMARY;
        7'h4E:   kind_w = utcp_pkg::UTCP_RPT_DETAIL;
        default: kind_w = kind_w;
      endcase
    end
  end

  logic cmd_g, cmd_h, go_rpt, go_alarm;

  assign cmd_g    = is_cr && len1 && (c0 == 7'h47);
  assign cmd_h    = is_cr && len1 && (c0 == 7'h48) && is_modem;
  assign go_rpt   = is_cr && (kind_w != utcp_pkg::UTCP_RPT_NONE);
  // waiting one cycle after any start keeps an alarm start from stretching the start pulse before it
  assign go_alarm = alarm_q && !is_modem && !go_rpt && !rpt_start;

  // --------------------------------------------------------------------------
  // line editing and command strobes
  // --------------------------------------------------------------------------
  // characters beyond the buffer are ignored; the return then acts on the first ten, so only a date or time line can match
  // each port instance edits its own line, so no port blocks another
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_q <= '0;
      len_q  <= '0;
    end else if (is_cr || is_freeze || is_quit) begin
      len_q <= '0;
    end else if (is_bs) begin
      if (len_q != '0) begin
        len_q <= len_q - `UTCP_IDX_W'(1);
      end
    end else if (rx_valid && (len_q != `UTCP_IDX_W'(`UTCP_LINE_LEN))) begin
      line_q[len_q] <= rx_char;
      len_q         <= len_q + `UTCP_IDX_W'(1);
    end
  end

  // pulses toward the report engine and the system clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpt_start  <= 1'b0;
      rpt_kind   <= utcp_pkg::UTCP_RPT_NONE;
      rpt_module <= 3'h0;
      rpt_abort  <= 1'b0;
      hist_reset <= 1'b0;
      date_load  <= 1'b0;
      time_load  <= 1'b0;
      hang_up    <= 1'b0;
    end else begin
      rpt_start  <= go_rpt || go_alarm;
      rpt_abort  <= is_quit || go_rpt || go_alarm;
      hist_reset <= cmd_g;
      hang_up    <= cmd_h;
      date_load  <= is_cr && is_date && clk_shape_ok;
      time_load  <= is_cr && is_time && clk_shape_ok;
      if (go_rpt) begin
        rpt_kind   <= kind_w;
        rpt_module <= mod_w;
      end else if (go_alarm) begin
        rpt_kind   <= utcp_pkg::UTCP_RPT_STATUS;
        rpt_module <= 3'h0;
      end
    end
  end

  // freeze toggles, buffer reset and quit both release it; an alarm rise is held until served,
  // so a level alarm starts one report instead of one every cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frozen_q   <= 1'b0;
      alarm_q    <= 1'b0;
      alarm_in_q <= 1'b0;
    end else begin
      if (is_freeze) begin
        frozen_q <= !frozen_q;
      end else if (cmd_g || is_quit) begin
        frozen_q <= 1'b0;
      end
      alarm_in_q <= new_alarm;
      alarm_q    <= (new_alarm && !alarm_in_q) || (alarm_q && !go_alarm && !is_modem);
    end
  end

  // suspension stalls the report engine instead of dropping characters
  assign rpt_ready = tx_ready && !frozen_q;

endmodule : utcp_port

/* utcp_term.sv */
`timescale 1ns/100ps
`include "utcp_defines.svh"

// ----------------------------------------
// terminal model on the far side of the port
// ----------------------------------------
module utcp_term (
  input  wire logic       sys_clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic [6:0]      rx_char,
  output logic            rx_par_ok,
  output logic [7:0]      rx_cnt
);
  localparam int DIV = `UTCP_DIV_HIGH; // local port runs 2400 only

  // one frame: start, 7 data lsb first, odd parity, stop
  task automatic send_char(input logic [6:0] c);
    logic [9:0] f;
    f = {1'b1, ~^c, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge sys_clk);
    end
  endtask : send_char

  // decode what the port sends, sampling mid-bit
  initial begin
    rxd = 1'b1;
    rx_cnt = 8'h00;
    rx_char = 7'h00;
    rx_par_ok = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (txd === 1'b0) begin
        repeat (DIV / 2) @(posedge sys_clk);
        for (int i = 0; i < 7; i++) begin
          repeat (DIV) @(posedge sys_clk);
          rx_char[i] = txd;
        end
        repeat (DIV) @(posedge sys_clk);
        rx_par_ok = (^{txd, rx_char}) === 1'b1;
        repeat (DIV) @(posedge sys_clk);
        rx_par_ok = rx_par_ok & (txd === 1'b1); // stop bit must be high
        rx_cnt = rx_cnt + 8'h01;
      end
    end
  end
endmodule : utcp_term

/* utcp_port_monitor.sv */
`timescale 1ns/100ps

// ----------------------------------------
// port checker
// ----------------------------------------
module utcp_port_monitor (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire logic                is_modem,
  input  wire logic                new_alarm,
  input  wire logic                txd,
  input  wire logic                rpt_start,
  input  utcp_pkg::utcp_rpt_t      rpt_kind,
  input  wire logic [2:0]          rpt_module,
  input  wire logic                rpt_valid,
  input  wire logic                rpt_ready,
  input  wire logic                rpt_abort,
  input  wire logic                hang_up
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_start_pulse; rpt_start |=> !rpt_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("report start held too long");
  property p_start_abort; rpt_start |-> rpt_abort; endproperty
  a_start_abort: assert property (p_start_abort) else $error("start without abort");
  property p_module_range; rpt_start |-> rpt_module <= 3'h6; endproperty
  a_module_range: assert property (p_module_range) else $error("module out of range");
  property p_kind_hold; !rpt_start |-> $stable(rpt_kind); endproperty
  a_kind_hold: assert property (p_kind_hold) else $error("kind moved without start");
  property p_hang_modem; hang_up |-> is_modem; endproperty
  a_hang_modem: assert property (p_hang_modem) else $error("hang up on local port");
  // the start bit must appear on txd two cycles after the take, else the frame shifts
  property p_take_start; rpt_valid && rpt_ready |=> !rpt_ready ##1 !txd; endproperty
  a_take_start: assert property (p_take_start) else $error("no start bit after take");
  property p_busy_hold; rpt_valid && rpt_ready |=> !rpt_ready [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("ready during frame");
  property p_idle_high; rpt_ready |-> txd; endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_alarm_rpt; $rose(new_alarm) && !is_modem |-> ##[1:300] rpt_start; endproperty
  a_alarm_rpt: assert property (p_alarm_rpt) else $error("alarm gave no report");

  c_start: cover property (rpt_start);
  c_hang: cover property (hang_up);
  c_take: cover property (rpt_valid && rpt_ready);
endmodule : utcp_port_monitor

bind utcp_port utcp_port_monitor i_mon (.sys_clk, .arst_n, .is_modem, .new_alarm, .txd, .rpt_start,
  .rpt_kind, .rpt_module, .rpt_valid, .rpt_ready, .rpt_abort, .hang_up);

/* tb_ups_terminal_command_parser.sv */
`timescale 1ns/100ps

// ----------------------------------------
// bench for one serial port
// ----------------------------------------
module tb_ups_terminal_command_parser;
  logic sys_clk, arst_n, is_modem, baud_low, rxd, txd, new_alarm, rpt_start, rpt_valid;
  logic rpt_ready, rpt_abort, hist_reset, date_load, time_load, hang_up, rx_par_ok;
  utcp_pkg::utcp_rpt_t rpt_kind;
  logic [2:0]          rpt_module;
  logic [2:0]          mod_q = 3'h0;
  logic [3:0]          kind_q = 4'h0;
  logic [6:0]          rpt_char, rx_char;
  logic [5:0][3:0]     clk_digits;
  logic [7:0]          rx_cnt;
  logic [7:0]          n_start = 8'h00, n_abort = 8'h00, n_hang = 8'h00, n_hist = 8'h00, n_load = 8'h00;
  int                  num_errors, total_checks;
  int                  cyc = 0;

  utcp_port i_dut (.sys_clk, .arst_n, .is_modem, .baud_low, .rxd, .txd, .new_alarm, .rpt_start,
    .rpt_kind, .rpt_module, .rpt_valid, .rpt_char, .rpt_ready, .rpt_abort, .hist_reset,
    .date_load, .time_load, .clk_digits, .hang_up);
  utcp_term i_term (.sys_clk, .txd, .rxd, .rx_char, .rx_par_ok, .rx_cnt);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // count pulses so tests can look after a serial frame ends
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000000) begin // about 29 frames of 83k cycles each plus one answer frame
      num_errors++;
      give_verdict();
    end
    if (rpt_start) begin
      n_start <= n_start + 8'h01;
      kind_q  <= rpt_kind;
      mod_q   <= rpt_module;
    end
    if (rpt_abort) n_abort <= n_abort + 8'h01;
    if (hang_up) n_hang <= n_hang + 8'h01;
    if (hist_reset) n_hist <= n_hist + 8'h01;
    if (date_load || time_load) n_load <= n_load + (time_load ? 8'h10 : 8'h01);
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic send_str(input string s);
    byte b;
    for (int i = 0; i < s.len(); i++) begin
      b = s[i];
      i_term.send_char(b[6:0]);
    end
  endtask : send_str

  task automatic t_alarm;
    logic [7:0] n0;
    n0 = n_start;
    new_alarm <= 1'b1;
    @(posedge sys_clk);
    new_alarm <= 1'b0;
    for (int i = 0; i < 300 && n_start === n0; i++) @(posedge sys_clk);
    check("alarm start", n_start, n0 + 8'h01);
    check("alarm kind", {4'h0, kind_q}, 8'h01);
    check("alarm module", {5'h00, mod_q}, 8'h00);
    $display("test alarm done");
  endtask : t_alarm

  // lower case letter, no digit: cabinet status
  task automatic t_status;
    logic [7:0] n0;
    n0 = n_start;
    send_str("a\x0D");
    check("status start", n_start, n0 + 8'h01);
    check("status kind", {4'h0, kind_q}, 8'h01);
    check("status module", {5'h00, mod_q}, 8'h00);
    $display("test status done");
  endtask : t_status

  // the backspace drops digit 5 so module 4 is asked
  task automatic t_hist;
    send_str("C5\x084\x0D");
    check("hist kind", {4'h0, kind_q}, 8'h03);
    check("hist module", {5'h00, mod_q}, 8'h04);
    $display("test history done");
  endtask : t_hist

  task automatic t_unknown;
    logic [7:0] n0;
    n0 = n_start;
    send_str("X\x0D");
    check("unknown start", n_start, n0);
    $display("test unknown done");
  endtask : t_unknown

  task automatic t_hang;
    is_modem <= 1'b1;
    send_str("h\x0D");
    check("hang pulses", n_hang, 8'h01);
    is_modem <= 1'b0;
    $display("test hang done");
  endtask : t_hang

  // freeze stalls the offered char; quit releases it and it goes out
  task automatic t_freeze;
    logic [7:0] a0, r0;
    send_str("F");
    rpt_char  <= 7'h41;
    rpt_valid <= 1'b1;
    repeat (50) @(posedge sys_clk);
    check("frozen ready", {7'h00, rpt_ready}, 8'h00);
    a0 = n_abort;
    r0 = rx_cnt;
    send_str("Q");
    check("quit abort", n_abort, a0 + 8'h01);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (rpt_ready === 1'b1) break;
    end
    rpt_valid <= 1'b0;
    for (int i = 0; i < 100000 && rx_cnt === r0; i++) @(posedge sys_clk);
    check("tx char", {1'b0, rx_char}, 8'h41);
    check("tx parity", {7'h00, rx_par_ok}, 8'h01);
    $display("test freeze done");
  endtask : t_freeze

  // control-B with digit 3 asks the event history of module 3
  task automatic t_events;
    logic [7:0] n0;
    n0 = n_start;
    send_str("\x023\x0D");
    check("events start", n_start, n0 + 8'h01);
    check("events kind", {4'h0, kind_q}, 8'h02);
    check("events module", {5'h00, mod_q}, 8'h03);
    $display("test events done");
  endtask : t_events

  // buffer reset gives one pulse and starts no report
  task automatic t_clear;
    logic [7:0] n0;
    n0 = n_start;
    send_str("g\x0D");
    check("clear pulses", n_hist, 8'h01);
    check("clear start", n_start, n0);
    $display("test clear done");
  endtask : t_clear

  // date digits land pairwise, the first pair in the low byte
  task automatic t_date;
    send_str("d 12/31/99\x0D");
    check("date pulses", n_load, 8'h01);
    check("date first", clk_digits[1:0], 8'h12);
    check("date second", clk_digits[3:2], 8'h31);
    check("date third", clk_digits[5:4], 8'h99);
    $display("test date done");
  endtask : t_date

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    {arst_n, is_modem, baud_low, new_alarm, rpt_valid} = 5'h00;
    rpt_char = 7'h00;
    {num_errors, total_checks} = '0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_alarm();
    t_status();
    t_events();
    t_hist();
    t_unknown();
    t_clear();
    t_date();
    t_hang();
    t_freeze();
    give_verdict();
  end
endmodule : tb_ups_terminal_command_parser
